/* pkg/thi_regs.svh */
// Register offsets, fields, reset values, characters and timing in nanoseconds
`ifndef THI_REGS_SVH
`define THI_REGS_SVH

`define THI_OFF_CTRL      8'h00
`define THI_OFF_DELCH     8'h04
`define THI_OFF_DIGIPEATER_DEFER_DELAY     8'h08
`define THI_OFF_STATUS    8'h0C

`define THI_CTRL_ECHO     0
`define THI_CTRL_ERASE    1
`define THI_CTRL_ALTPOS   2
`define THI_CTRL_IFACE    4

`define THI_RST_ECHO      1'b1
`define THI_RST_ERASE     1'b1
`define THI_RST_ALTPOS    1'b0
`define THI_RST_DELCH     8'h08
`define THI_RST_DIGIPEATER_DEFER_DELAY     8'h03

`define THI_CH_CTRLC      8'h03
`define THI_CH_BS         8'h08
`define THI_STR_PROMPT    32'h3A646D63
`define THI_LEN_PROMPT    3'h4
`define THI_STR_ERASE     32'h00082008
`define THI_LEN_ERASE     3'h3
`define THI_STR_BSLASH    32'h0000005C
`define THI_STR_ERROR     32'h003F4845
`define THI_LEN_ERROR     3'h3
`define THI_ESC_COUNT     2'h3

`define THI_CLK_NS        40
`define THI_CTRLC_GAP_NS  1000000000
`define THI_DIGIPEATER_DEFER_DELAY_UNIT_NS 10000000

`endif

/* pkg/thi_pkg.sv */
// Types shared by the host interpreter
package thi_pkg;
	typedef enum logic [1:0] {
		MODE_CMD   = 2'b00,
		MODE_CONV  = 2'b01,
		MODE_TRANSPARENT_MODE = 2'b10
	} thi_mode_e;

	typedef enum logic [1:0] {
		IF_BASIC = 2'b00,
		IF_FULL  = 2'b01,
		IF_HOST  = 2'b10,
		IF_KISS  = 2'b11
	} thi_iface_e;

	typedef enum logic [2:0] {
		OP_DONE  = 3'b000,
		OP_CONV  = 3'b001,
		OP_TRANSPARENT_MODE = 3'b010,
		OP_IFACE = 3'b011,
		OP_BAD   = 3'b100
	} thi_op_e;

	typedef struct packed {
		thi_op_e    op;
		logic [2:0] arg;
	} thi_cmd_s;

	typedef struct packed {
		logic       del;
		logic [7:0] data;
	} thi_char_s;

	typedef logic [3:0][7:0] thi_str_t;
endpackage

/* rtl/thi_pin_sync.sv */
// Three-stage pin synchronisers with agreement filter
`timescale 1ns/1ps
module thi_pin_sync (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Pins and synchronised levels
	input  wire logic [1:0] pin_in,
	output logic      [1:0] pin_out
);
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic out_reg;

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_reg  <= 1'b1;
					s2_reg  <= 1'b1;
					s3_reg  <= 1'b1;
					out_reg <= 1'b1;
				end else begin
					s1_reg <= pin_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						out_reg <= s3_reg;
					end
				end
			end

			assign pin_out[i] = out_reg;
		end
	endgenerate
endmodule // thi_pin_sync

/* rtl/thi_interp.sv */
// Host character interpreter with AXI4-Lite control registers
`timescale 1ns/1ps
`include "thi_regs.svh"
module thi_interp #(
	parameter int GAP_CYC  = `THI_CTRLC_GAP_NS / `THI_CLK_NS,
	parameter int UNIT_CYC = `THI_DIGIPEATER_DEFER_DELAY_UNIT_NS / `THI_CLK_NS
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Host characters in
	input  wire logic              host_valid,
	input  wire logic [7:0]        host_data,
	output logic                   host_ready,
	// Command parser
	output logic                   cmd_char_valid,
	output logic [7:0]             cmd_char_data,
	input  wire logic              cmd_done_valid,
	input  wire thi_pkg::thi_cmd_s cmd_done,
	output logic                   cmd_done_ready,
	// Transmit queue
	output logic                   tx_valid,
	output thi_pkg::thi_char_s     tx_item,
	input  wire logic              tx_ready,
	// Terminal output
	output logic                   term_valid,
	output logic [7:0]             term_data,
	input  wire logic              term_ready,
	// Link and radio keying
	input  wire logic              link_up,
	input  wire logic              chan_busy,
	input  wire logic              tx_pending,
	output logic                   ptt,
	// Position receiver pins
	input  wire logic              host_txd_pin,
	input  wire logic              radio_pos_pin,
	output logic                   pos_rxd,
	// Current mode
	output thi_pkg::thi_mode_e     mode
);
	localparam int GW = $clog2(GAP_CYC + 1);
	localparam int UW = $clog2(UNIT_CYC + 1);

	thi_pkg::thi_mode_e  mode_reg;
	thi_pkg::thi_iface_e iface_reg;
	thi_pkg::thi_str_t   str_reg;
	thi_pkg::thi_str_t   str_next;
	logic          echo_reg;
	logic          erase_reg;
	logic          altpos_reg;
	logic [7:0]    delch_reg;
	logic [7:0]    digipeater_defer_delay_reg;
	logic          link_reg;
	logic          prompt_reg;
	logic          busy_reg;
	logic [1:0]    idx_reg;
	logic [2:0]    len_reg;
	logic [2:0]    len_next;
	logic          load;
	logic [1:0]    cc_reg;
	logic [GW-1:0] gap_reg;
	logic [UW-1:0] unit_reg;
	logic [7:0]    defer_reg;
	logic [1:0]    pins_sync;
	logic          host_take;
	logic          cmd_take;
	logic          link_rise;
	logic          link_fall;
	logic          is_exit;
	logic          is_del;
	logic          cc_third;
	logic          bad_param;
	logic          wr_go;
	logic [7:0]    wr_off;
	logic [7:0]    rd_off;
	logic          unit_tick;

	assign mode      = mode_reg;
	assign link_rise = link_up && !link_reg;
	assign link_fall = !link_up && link_reg;
	assign is_exit   = host_data == `THI_CH_CTRLC;
	assign is_del    = host_data == delch_reg;
	assign cc_third  = is_exit && (cc_reg == `THI_ESC_COUNT - 2'h1)
		&& (gap_reg < GW'(GAP_CYC));

	// Parser results first, then host characters, one at a time
	assign cmd_done_ready = !busy_reg && !prompt_reg;
	assign cmd_take       = cmd_done_valid && cmd_done_ready;
	assign host_ready     = !busy_reg && !prompt_reg && !cmd_done_valid
		&& !tx_valid;
	assign host_take      = host_valid && host_ready;

	assign bad_param = (cmd_done.op == thi_pkg::OP_BAD)
		|| (cmd_done.op == thi_pkg::OP_IFACE && cmd_done.arg[2])
		|| (cmd_done.op == thi_pkg::OP_TRANSPARENT_MODE
		&& iface_reg != thi_pkg::IF_FULL);

	// Mode state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= thi_pkg::MODE_CMD;
			link_reg <= 1'b0;
		end else begin
			link_reg <= link_up;
			if (link_rise) begin
				mode_reg <= thi_pkg::MODE_CONV;
			end else if (link_fall) begin
				mode_reg <= thi_pkg::MODE_CMD;
			end else if (cmd_take) begin
				if (cmd_done.op == thi_pkg::OP_CONV
					&& mode_reg == thi_pkg::MODE_CMD) begin
					mode_reg <= thi_pkg::MODE_CONV;
				end else if (cmd_done.op == thi_pkg::OP_TRANSPARENT_MODE
					&& iface_reg == thi_pkg::IF_FULL) begin
					mode_reg <= thi_pkg::MODE_TRANSPARENT_MODE;
				end
			end else if (host_take) begin
				if (mode_reg == thi_pkg::MODE_CONV && is_exit) begin
					mode_reg <= thi_pkg::MODE_CMD;
				end else if (mode_reg == thi_pkg::MODE_TRANSPARENT_MODE
					&& cc_third) begin
					mode_reg <= thi_pkg::MODE_CMD;
				end
			end
		end
	end

	// Escape counter for transparent mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cc_reg  <= 2'h0;
			gap_reg <= '0;
		end else begin
			if (gap_reg < GW'(GAP_CYC)) begin
				gap_reg <= gap_reg + GW'(1);
			end
			if (host_take && mode_reg == thi_pkg::MODE_TRANSPARENT_MODE) begin
				if (!is_exit || cc_third) begin
					cc_reg <= 2'h0;
				end else if (cc_reg == 2'h0
					|| gap_reg < GW'(GAP_CYC)) begin
					cc_reg  <= cc_reg + 2'h1;
					gap_reg <= '0;
				end else begin
					cc_reg  <= 2'h1;
					gap_reg <= '0;
				end
			end else if (mode_reg != thi_pkg::MODE_TRANSPARENT_MODE) begin
				cc_reg <= 2'h0;
			end
		end
	end

	// Command character path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_char_valid <= 1'b0;
			cmd_char_data  <= 8'h00;
		end else begin
			cmd_char_valid <= host_take
				&& mode_reg == thi_pkg::MODE_CMD;
			if (host_take) begin
				cmd_char_data <= host_data;
			end
		end
	end

	// Transmit slot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_valid <= 1'b0;
			tx_item  <= '0;
		end else if (host_take
			&& mode_reg == thi_pkg::MODE_TRANSPARENT_MODE) begin
			tx_valid     <= 1'b1;
			tx_item.del  <= 1'b0;
			tx_item.data <= host_data;
		end else if (host_take && mode_reg == thi_pkg::MODE_CONV
			&& !is_exit) begin
			tx_valid     <= 1'b1;
			tx_item.del  <= is_del;
			tx_item.data <= host_data;
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	// Terminal string selection
	always_comb begin
		load     = 1'b0;
		len_next = 3'h1;
		str_next = {24'h000000, host_data};
		if (prompt_reg) begin
			load     = 1'b1;
			len_next = `THI_LEN_PROMPT;
			str_next = `THI_STR_PROMPT;
		end else if (cmd_take) begin
			if (bad_param) begin
				load     = 1'b1;
				len_next = `THI_LEN_ERROR;
				str_next = `THI_STR_ERROR;
			end else if (cmd_done.op == thi_pkg::OP_DONE
				|| cmd_done.op == thi_pkg::OP_IFACE) begin
				load     = 1'b1;
				len_next = `THI_LEN_PROMPT;
				str_next = `THI_STR_PROMPT;
			end
		end else if (host_take) begin
			if ((mode_reg == thi_pkg::MODE_CONV && is_exit)
				|| (mode_reg == thi_pkg::MODE_TRANSPARENT_MODE && cc_third)) begin
				load     = 1'b1;
				len_next = `THI_LEN_PROMPT;
				str_next = `THI_STR_PROMPT;
			end else if (mode_reg == thi_pkg::MODE_CONV && is_del) begin
				load = echo_reg;
				if (erase_reg) begin
					len_next = `THI_LEN_ERASE;
					str_next = `THI_STR_ERASE;
				end else begin
					str_next = `THI_STR_BSLASH;
				end
			end else if (mode_reg != thi_pkg::MODE_TRANSPARENT_MODE) begin
				load = echo_reg;
			end
		end
	end

	// Terminal string sender
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg <= 1'b0;
			idx_reg  <= 2'h0;
			len_reg  <= 3'h0;
			str_reg  <= '0;
		end else if (!busy_reg) begin
			if (load) begin
				busy_reg <= 1'b1;
				idx_reg  <= 2'h0;
				len_reg  <= len_next;
				str_reg  <= str_next;
			end
		end else if (term_ready) begin
			if ({1'b0, idx_reg} == len_reg - 3'h1) begin
				busy_reg <= 1'b0;
			end else begin
				idx_reg <= idx_reg + 2'h1;
			end
		end
	end

	assign term_valid = busy_reg;
	assign term_data  = str_reg[idx_reg];

	// Prompt after link loss; a new loss wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prompt_reg <= 1'b0;
		end else if (link_fall) begin
			prompt_reg <= 1'b1;
		end else if (!busy_reg) begin
			prompt_reg <= 1'b0;
		end
	end

	// Digipeater defer before keying
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unit_reg  <= '0;
			defer_reg <= 8'h00;
			ptt       <= 1'b0;
		end else begin
			unit_reg <= unit_tick ? '0 : unit_reg + UW'(1);
			if (chan_busy) begin
				defer_reg <= 8'h00;
			end else if (unit_tick && defer_reg < digipeater_defer_delay_reg) begin
				defer_reg <= defer_reg + 8'h01;
			end
			ptt <= tx_pending && !chan_busy
				&& defer_reg >= digipeater_defer_delay_reg;
		end
	end

	assign unit_tick = unit_reg == UW'(UNIT_CYC - 1);

	// Position input selection
	thi_pin_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin_in  ({radio_pos_pin, host_txd_pin}),
		.pin_out (pins_sync)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_rxd <= 1'b1;
		end else begin
			pos_rxd <= altpos_reg ? pins_sync[1] : pins_sync[0];
		end
	end

	// AXI4-Lite write side
	assign wr_go   = awvalid && wvalid && !bvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign wr_off  = {awaddr[7:2], 2'b00};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid     <= 1'b0;
			bresp      <= 2'b00;
			echo_reg   <= `THI_RST_ECHO;
			erase_reg  <= `THI_RST_ERASE;
			altpos_reg <= `THI_RST_ALTPOS;
			iface_reg  <= thi_pkg::IF_BASIC;
			delch_reg  <= `THI_RST_DELCH;
			digipeater_defer_delay_reg  <= `THI_RST_DIGIPEATER_DEFER_DELAY;
		end else begin
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= 2'b00;
				if (wr_off == `THI_OFF_CTRL && wstrb[0]) begin
					echo_reg   <= wdata[`THI_CTRL_ECHO];
					erase_reg  <= wdata[`THI_CTRL_ERASE];
					altpos_reg <= wdata[`THI_CTRL_ALTPOS];
					iface_reg  <= thi_pkg::thi_iface_e'(
						wdata[`THI_CTRL_IFACE +: 2]);
				end else if (wr_off == `THI_OFF_DELCH && wstrb[0]) begin
					delch_reg <= wdata[7:0];
				end else if (wr_off == `THI_OFF_DIGIPEATER_DEFER_DELAY && wstrb[0]) begin
					digipeater_defer_delay_reg <= wdata[7:0];
				end else if (wr_off != `THI_OFF_CTRL
					&& wr_off != `THI_OFF_DELCH
					&& wr_off != `THI_OFF_DIGIPEATER_DEFER_DELAY
					&& wr_off != `THI_OFF_STATUS) begin
					bresp <= 2'b10;
				end
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (cmd_take && cmd_done.op == thi_pkg::OP_IFACE
				&& !bad_param) begin
				iface_reg <= thi_pkg::thi_iface_e'(cmd_done.arg[1:0]);
			end
		end
	end

	// AXI4-Lite read side
	assign arready = !rvalid;
	assign rd_off  = {araddr[7:2], 2'b00};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= 2'b00;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= 2'b00;
			rdata  <= 32'h00000000;
			unique case (rd_off)
				`THI_OFF_CTRL: begin
					rdata[`THI_CTRL_ECHO]      <= echo_reg;
					rdata[`THI_CTRL_ERASE]     <= erase_reg;
					rdata[`THI_CTRL_ALTPOS]    <= altpos_reg;
					rdata[`THI_CTRL_IFACE +: 2] <= iface_reg;
				end
				`THI_OFF_DELCH: rdata[7:0] <= delch_reg;
				`THI_OFF_DIGIPEATER_DEFER_DELAY: rdata[7:0] <= digipeater_defer_delay_reg;
				`THI_OFF_STATUS: rdata[7:0] <= {ptt, link_up,
					cc_reg, tx_valid, busy_reg, mode_reg};
				default: rresp <= 2'b10;
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cmd_no_tx: assert property (
		host_take && mode_reg == thi_pkg::MODE_CMD
		|=> cmd_char_valid && !tx_valid
		&& cmd_char_data == $past(host_data))
		else $error("command character leaked to transmit");

	a_conv_exit: assert property (
		host_take && mode_reg == thi_pkg::MODE_CONV && is_exit
		&& !link_rise && !link_fall
		|=> mode_reg == thi_pkg::MODE_CMD && !tx_valid
		&& term_valid && term_data == 8'h63
		##1 term_valid)
		else $error("control-C did not return to command mode");

	a_conv_queue: assert property (
		host_take && mode_reg == thi_pkg::MODE_CONV && !is_exit
		&& !is_del |=> tx_valid && !tx_item.del
		&& tx_item.data == $past(host_data))
		else $error("conversation character not queued");

	a_conv_delete: assert property (
		host_take && mode_reg == thi_pkg::MODE_CONV && !is_exit
		&& is_del |=> tx_valid && tx_item.del)
		else $error("delete character not marked");

	a_transparent_mode_fwd: assert property (
		host_take && mode_reg == thi_pkg::MODE_TRANSPARENT_MODE
		|=> tx_valid && tx_item.data == $past(host_data)
		&& !tx_item.del)
		else $error("transparent character not forwarded");

	a_link_modes: assert property (
		link_rise |=> mode_reg == thi_pkg::MODE_CONV)
		else $error("link up did not enter conversation");

	a_link_down: assert property (
		link_fall |=> mode_reg == thi_pkg::MODE_CMD && prompt_reg)
		else $error("link down did not enter command mode");

	a_transparent_mode_basic: assert property (
		cmd_take && cmd_done.op == thi_pkg::OP_TRANSPARENT_MODE
		&& iface_reg != thi_pkg::IF_FULL && !link_rise
		|=> mode_reg != thi_pkg::MODE_TRANSPARENT_MODE && term_data == 8'h45)
		else $error("transparent accepted under basic set");

	a_bad_param: assert property (
		cmd_take && cmd_done.op == thi_pkg::OP_IFACE
		&& cmd_done.arg[2] && !wr_go
		|=> $stable(iface_reg) && term_valid)
		else $error("illegal parameter changed the setting");

	a_echo_off: assert property (
		!echo_reg && host_take && mode_reg == thi_pkg::MODE_CMD
		|=> !term_valid)
		else $error("echo occurred while disabled");

	a_ptt_defer: assert property (
		chan_busy |=> !ptt)
		else $error("keyed while channel busy");
endmodule // thi_interp

/* tb/thi_far_model.sv */
// Far-side sinks for terminal, transmit queue and parser characters
`timescale 1ns/1ps
module thi_far_model (
	// Clock
	input  wire logic               aclk,
	// Terminal output
	input  wire logic               term_valid,
	input  wire logic [7:0]         term_data,
	output logic                    term_ready,
	// Transmit queue
	input  wire logic               tx_valid,
	input  wire thi_pkg::thi_char_s tx_item,
	output logic                    tx_ready,
	// Parser characters
	input  wire logic               cmd_char_valid,
	input  wire logic [7:0]         cmd_char_data
);
	logic [7:0] term_q[$];
	logic [8:0] tx_q[$];
	logic [7:0] cmd_q[$];

	initial begin
		term_ready = 1'b0;
		tx_ready   = 1'b0;
	end

	// Record every item taken, stall at random
	always @(posedge aclk) begin
		if (term_valid && term_ready)
			term_q.push_back(term_data);
		if (tx_valid && tx_ready)
			tx_q.push_back(tx_item);
		if (cmd_char_valid)
			cmd_q.push_back(cmd_char_data);
		term_ready <= ($urandom % 3) != 0;
		tx_ready   <= ($urandom % 3) != 0;
	end
endmodule // thi_far_model

/* tb/test_thi_interp.sv */
// Self-checking bench for the host character interpreter
`timescale 1ns/1ps
`include "thi_regs.svh"
module test_thi_interp;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, host_data, cmd_char_data, term_data;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic host_valid, host_ready, cmd_char_valid, cmd_done_valid;
	logic cmd_done_ready, tx_valid, tx_ready, term_valid, term_ready;
	logic link_up, chan_busy, tx_pending, ptt;
	logic host_txd_pin, radio_pos_pin, pos_rxd;
	thi_pkg::thi_cmd_s  cmd_done;
	thi_pkg::thi_char_s tx_item;
	thi_pkg::thi_mode_e mode, m_mode;
	logic [8:0] e_tx[$];
	logic [7:0] e_cmd[$];
	logic [7:0] m_del;
	int err_count, n_checks, m_cc, cyc;

	thi_interp #(.GAP_CYC(200), .UNIT_CYC(8)) DUT (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .host_valid(host_valid),
		.host_data(host_data), .host_ready(host_ready),
		.cmd_char_valid(cmd_char_valid),
		.cmd_char_data(cmd_char_data),
		.cmd_done_valid(cmd_done_valid), .cmd_done(cmd_done),
		.cmd_done_ready(cmd_done_ready), .tx_valid(tx_valid),
		.tx_item(tx_item), .tx_ready(tx_ready),
		.term_valid(term_valid), .term_data(term_data),
		.term_ready(term_ready), .link_up(link_up),
		.chan_busy(chan_busy), .tx_pending(tx_pending), .ptt(ptt),
		.host_txd_pin(host_txd_pin), .radio_pos_pin(radio_pos_pin),
		.pos_rxd(pos_rxd), .mode(mode)
	);

	thi_far_model p (
		.aclk(aclk), .term_valid(term_valid), .term_data(term_data),
		.term_ready(term_ready), .tx_valid(tx_valid),
		.tx_item(tx_item), .tx_ready(tx_ready),
		.cmd_char_valid(cmd_char_valid), .cmd_char_data(cmd_char_data)
	);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic close_out();
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 50000) begin
			err_count++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do @(negedge aclk); while (awready !== 1'b1);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		do @(negedge aclk); while (bvalid !== 1'b1);
		chk(bresp, r);
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		chk(rdata, d);
		chk(rresp, r);
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Wait for outputs to drain, then compare with the model
	task automatic drain();
		logic [8:0] g;
		logic [8:0] e;
		for (int i = 0; i < 300; i++) begin
			@(negedge aclk);
			if (host_ready === 1'b1 && tx_valid === 1'b0 &&
					term_valid === 1'b0)
				break;
		end
		@(negedge aclk);
		chk(p.tx_q.size(), e_tx.size());
		while (e_tx.size() > 0 && p.tx_q.size() > 0) begin
			g = p.tx_q.pop_front();
			e = e_tx.pop_front();
			if (e[8])
				g[7:0] = 8'h00;
			chk(g, e);
		end
		chk(p.cmd_q.size(), e_cmd.size());
		while (e_cmd.size() > 0 && p.cmd_q.size() > 0)
			chk(p.cmd_q.pop_front(), e_cmd.pop_front());
		chk(mode, m_mode);
		e_tx.delete();
		e_cmd.delete();
	endtask

	// Send one host character through the behavioural model
	task automatic hc(input logic [7:0] c);
		if (m_mode == thi_pkg::MODE_CMD) begin
			e_cmd.push_back(c);
		end else if (m_mode == thi_pkg::MODE_CONV) begin
			if (c == `THI_CH_CTRLC)
				m_mode = thi_pkg::MODE_CMD;
			else
				e_tx.push_back(c == m_del ? 9'h100 : {1'b0, c});
		end else begin
			e_tx.push_back({1'b0, c});
			m_cc = (c == `THI_CH_CTRLC) ? m_cc + 1 : 0;
			if (m_cc == 3)
				m_mode = thi_pkg::MODE_CMD;
		end
		@(posedge aclk);
		host_data  <= c;
		host_valid <= 1'b1;
		do @(negedge aclk); while (host_ready !== 1'b1);
		@(posedge aclk);
		host_valid <= 1'b0;
		drain();
	endtask

	task automatic ps(input logic [2:0] o, input logic [2:0] a,
			input thi_pkg::thi_mode_e m);
		@(posedge aclk);
		cmd_done       <= {o, a};
		cmd_done_valid <= 1'b1;
		do @(negedge aclk); while (cmd_done_ready !== 1'b1);
		@(posedge aclk);
		cmd_done_valid <= 1'b0;
		m_mode = m;
		m_cc = 0;
		drain();
	endtask

	// Compare the end of the terminal stream, then clear it
	task automatic tail(input string s);
		int n;
		int b;
		n = s.len();
		b = p.term_q.size() - n;
		chk(b >= 0, 1);
		for (int i = 0; i < n; i++)
			if (b + i >= 0)
				chk(p.term_q[b + i], s[i]);
		p.term_q.delete();
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{host_valid, cmd_done_valid, link_up, chan_busy} = '0;
		{awaddr, araddr, host_data, wdata, cmd_done} = '0;
		tx_pending = 1'b0;
		wstrb = 4'hF;
		host_txd_pin = 1'b1;
		radio_pos_pin = 1'b1;
		m_mode = thi_pkg::MODE_CMD;
		m_del = `THI_RST_DELCH;
		void'($urandom(60));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`THI_OFF_CTRL, 32'h03, 2'h0);
		rd(`THI_OFF_DELCH, 32'h08, 2'h0);
		rd(`THI_OFF_DIGIPEATER_DEFER_DELAY, 32'h03, 2'h0);
		rd(8'h14, 32'h0, 2'h2);
		wr(8'h10, 32'h0, 2'h2);
		hc("X");
		tail("X");
		ps(3'h0, 3'h0, thi_pkg::MODE_CMD);
		tail("cmd:");
		ps(3'h2, 3'h0, thi_pkg::MODE_CMD);
		tail("EH?");
		for (int i = 0; i < 4; i++) begin
			ps(3'h3, 3'((i + 2) % 4), thi_pkg::MODE_CMD);
			tail("cmd:");
			rd(`THI_OFF_CTRL, {26'h0, 2'((i + 2) % 4), 4'h3},
				2'h0);
		end
		ps(3'h3, 3'h5, thi_pkg::MODE_CMD);
		tail("EH?");
		rd(`THI_OFF_CTRL, 32'h13, 2'h0);
		ps(3'h4, 3'h0, thi_pkg::MODE_CMD);
		tail("EH?");
		wr(`THI_OFF_CTRL, 32'h12, 2'h0);
		hc("Y");
		chk(p.term_q.size(), 0);
		wr(`THI_OFF_CTRL, 32'h13, 2'h0);
		ps(3'h1, 3'h0, thi_pkg::MODE_CONV);
		repeat (3) hc(8'h41 + 8'($urandom % 26));
		hc(`THI_CH_BS);
		tail("\010 \010");
		wr(`THI_OFF_DELCH, 32'h7F, 2'h0);
		wr(`THI_OFF_CTRL, 32'h11, 2'h0);
		m_del = 8'h7F;
		hc(8'h7F);
		tail("\\");
		hc(`THI_CH_CTRLC);
		tail("cmd:");
		ps(3'h2, 3'h0, thi_pkg::MODE_TRANSPARENT_MODE);
		hc(`THI_CH_BS);
		hc(8'h7F);
		repeat (2) hc(`THI_CH_CTRLC);
		repeat (300) @(posedge aclk);
		m_cc = 0;
		repeat (3) hc(`THI_CH_CTRLC);
		tail("cmd:");
		@(posedge aclk);
		link_up <= 1'b1;
		m_mode = thi_pkg::MODE_CONV;
		drain();
		@(posedge aclk);
		link_up <= 1'b0;
		m_mode = thi_pkg::MODE_CMD;
		repeat (2) @(posedge aclk);
		drain();
		tail("cmd:");
		@(posedge aclk);
		host_txd_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		chk(pos_rxd, 1'b0);
		wr(`THI_OFF_CTRL, 32'h15, 2'h0);
		repeat (8) @(posedge aclk);
		chk(pos_rxd, 1'b1);
		radio_pos_pin <= 1'b0;
		host_txd_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(pos_rxd, 1'b0);
		tx_pending <= 1'b1;
		chan_busy <= 1'b1;
		repeat (5) @(posedge aclk);
		chk(ptt, 1'b0);
		chan_busy <= 1'b0;
		repeat (10) @(posedge aclk);
		chk(ptt, 1'b0);
		repeat (30) @(posedge aclk);
		chk(ptt, 1'b1);
		close_out();
	end
endmodule // test_thi_interp
